/* design/adcs_clkdiv.sv */
`timescale 1ns/1ps
module adcs_clkdiv
   import adcs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [2:0] sel,
   input wire logic restart,
   output logic tick
);
   logic [5:0] cnt_ff;
   logic [5:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;
   wire [6:0] div_span = 7'h01 << sel;
   wire [5:0] div_last = 6'(div_span - 7'h01);
   wire at_last = (cnt_ff == div_last);

   // code 111 gives no ticks at all, so a conversion simply never ends
   always_comb begin
      nxt_cnt = 6'h00;
      nxt_tick = 1'b0;
      if (!restart && sel != DIV_UNDEF) begin
         nxt_cnt = at_last ? 6'h00 : 6'(cnt_ff + 6'h01);
         nxt_tick = at_last;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_ff <= 6'h00;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

   div_eight_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (tick && !restart && sel == 3'h3) ##1 (!restart && sel == 3'h3)[*8] |-> tick)
   else $error("divide by eight tick spacing wrong");
endmodule

/* design/adcs_pkg.sv */
package adcs_pkg;
   // register offsets
   localparam logic [3:0] ADDR_CTRL_A = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B = 4'h1;
   localparam logic [3:0] ADDR_PIN_LO = 4'h2;
   localparam logic [3:0] ADDR_PIN_HI = 4'h3;
   localparam logic [3:0] ADDR_RES_LO = 4'h4;
   localparam logic [3:0] ADDR_RES_HI = 4'h5;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h6;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h7;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
   // field positions
   localparam int CA_START_BIT = 7;
   localparam int CA_BUSY_BIT = 6;
   localparam int CA_POFF_BIT = 5;
   localparam int CB_CH4_BIT = 7;
   localparam int IE_GLOBAL_BIT = 0;
   localparam int IE_CONV_BIT = 1;
   localparam int ST_DONE_BIT = 0;
   // reset values
   localparam logic [7:0] CTRL_A_RST = 8'h20;
   localparam logic [2:0] DIV_SEL_RST = 3'h0;
   localparam logic [11:0] PIN_EN_RST = 12'h000;
   localparam logic [4:0] CHAN_RST = 5'h00;
   // timing and conversion
   localparam logic [2:0] DIV_UNDEF = 3'h7;
   localparam logic [4:0] CONV_TICKS = 5'h10;
   localparam logic [4:0] SAR_FIRST_STEP = 5'h01;
   localparam logic [4:0] SAR_LAST_STEP = 5'h0c;
   localparam logic [4:0] SAR_DONE_STEP = 5'h0f;
   localparam logic [11:0] SAR_MSB_TRIAL = 12'h800;
   localparam logic [11:0] RES_FULL_SCALE = 12'hfff;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} adcs_state_t;
endpackage

/* design/adcs_sar.sv */
`timescale 1ns/1ps
module adcs_sar
   import adcs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic run,
   input wire logic tick,
   input wire logic cmp_above,
   output logic [12:0] dac_threshold,
   output logic [11:0] result,
   output logic done
);
   logic [4:0] step_ff;
   logic [11:0] trial_ff;
   logic [11:0] nxt_trial;
   logic [11:0] result_ff;
   logic [12:0] dac_ff;
   logic done_ff;
   wire deciding = (step_ff >= SAR_FIRST_STEP) && (step_ff <= SAR_LAST_STEP);
   wire [4:0] bit_idx = 5'(SAR_LAST_STEP - step_ff);
   wire step_go = run && tick;
   // a conversion cleared by power-off in its last tick keeps the previous result
   wire finish = step_go && !clear && (step_ff == SAR_DONE_STEP);

   // one bit decided per conversion clock in steps 1 to 12, the next one tried at once
   always_comb begin
      nxt_trial = trial_ff;
      for (int i = 0; i < 12; i++) begin
         if (deciding && bit_idx == 5'(i)) nxt_trial[i] = cmp_above;
         if (deciding && bit_idx == 5'(i + 1)) nxt_trial[i] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || clear) begin
         step_ff <= 5'h00;
         trial_ff <= SAR_MSB_TRIAL;
         done_ff <= 1'b0;
      end else begin
         done_ff <= finish;
         if (step_go) begin
            step_ff <= 5'(step_ff + 5'h01);
            trial_ff <= nxt_trial;
         end
      end
   end

   // threshold in half steps: code k switches half a step early, so fff lands 1.5 steps below ref
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dac_ff <= 13'h0000;
         result_ff <= 12'h000;
      end else begin
         dac_ff <= (step_go ? nxt_trial : trial_ff) == 12'h000 ? 13'h0000 :
                   13'({(step_go ? nxt_trial : trial_ff), 1'b0} - 13'h0001);
         if (finish) result_ff <= trial_ff;
      end
   end

   assign dac_threshold = dac_ff;
   assign result = result_ff;
   assign done = done_ff;
endmodule

/* design/adcs_top.sv */
// What this block does
// - conversion clock comes from the system clock via a three-bit select field.
// - select codes 000 to 110 divide by 1 to 64; 111 is undefined.
// - converter runs only while power-off is clear; setting it switches circuitry off.
// - five-bit channel select, split over both control registers, routes the input.
// - twelve pin-enable bits in two registers make each pin an analog input.
// - completion interrupt needs both global and converter interrupt enables set.
// - start bit low-high-low; rising edge resets converter, falling edge starts it.
// - busy flag high during conversion, low at completion; result then readable.
// - a conversion lasts sixteen conversion-clock periods; the processor keeps running.
// - result is twelve bits, full scale fff, one step is reference over 4096.
// - code transitions sit half a step early; last one 1.5 steps below reference.
// - interrupt is taken only when enabled and the call stack is not full.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module adcs_top
   import adcs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic cmp_above,
   input wire logic stack_full,
   output logic [12:0] dac_threshold,
   output logic sample_hold,
   output logic converter_power_off,
   output logic [4:0] input_channel_sel,
   output logic [11:0] analog_pin_enables,
   output logic conv_busy_flag,
   output logic irq
);
   import adcs_pkg::*;

   // software-visible state
   logic start_ff;
   logic poff_ff;
   logic busy_ff;
   logic [4:0] chan_ff;
   logic [2:0] div_sel_ff;
   logic [11:0] pin_en_ff;
   logic [1:0] irq_en_ff;
   logic status_ff;
   logic mask_ff;
   logic [7:0] rdata_ff;
   logic irq_ff;
   logic sample_ff;
   adcs_state_t st_ff;
   adcs_state_t nxt_st;
   logic nxt_busy;
   logic nxt_status;
   logic nxt_irq;

   // helper count of conversion clocks seen by the running conversion
   logic [4:0] run_ticks_ff;

   // converter datapath
   logic conv_tick;
   logic sar_done;
   logic [11:0] sar_result;
   logic [12:0] sar_dac;

   // write decode and status read decode
   wire wr_ctrl_a = reg_wr && (reg_addr == ADDR_CTRL_A);
   wire wr_ctrl_b = reg_wr && (reg_addr == ADDR_CTRL_B);
   wire wr_pin_lo = reg_wr && (reg_addr == ADDR_PIN_LO);
   wire wr_pin_hi = reg_wr && (reg_addr == ADDR_PIN_HI);
   wire wr_irq_en = reg_wr && (reg_addr == ADDR_IRQ_EN);
   wire wr_mask = reg_wr && (reg_addr == ADDR_IRQ_MASK);
   wire rd_status = reg_rd && (reg_addr == ADDR_IRQ_STAT);

   // start bit edges are seen on the write that changes it
   wire start_new = reg_wdata[CA_START_BIT];
   wire start_rise = wr_ctrl_a && start_new && !start_ff;
   wire start_fall = wr_ctrl_a && !start_new && start_ff;

   // the power-off bit takes effect in the same cycle it is written
   wire poff_next = wr_ctrl_a ? reg_wdata[CA_POFF_BIT] : poff_ff;

   wire in_conv = (st_ff == ST_CONV);
   // power-off clears the converter at once so no late completion slips out
   wire sar_clear = (st_ff != ST_CONV) || poff_next;
   wire global_en = irq_en_ff[IE_GLOBAL_BIT];
   wire conv_en = irq_en_ff[IE_CONV_BIT];

   // conversion sequencing
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         ST_IDLE: begin
            if (start_rise) nxt_st = ST_ARMED;
         end
         ST_ARMED: begin
            if (start_fall) nxt_st = ST_CONV;
         end
         ST_CONV: begin
            if (start_rise) nxt_st = ST_ARMED;
            else if (sar_done) nxt_st = ST_IDLE;
         end
      endcase
      if (poff_next) nxt_st = ST_IDLE;
   end

   // busy rises with the start edge so a poll right after starting never sees a stale low
   always_comb begin
      nxt_busy = busy_ff;
      if (start_rise) nxt_busy = 1'b1;
      if (in_conv && sar_done && !start_rise) nxt_busy = 1'b0;
      if (poff_next) nxt_busy = 1'b0;
   end

   // a completion in the same cycle as the clearing read still sets the flag
   always_comb begin
      nxt_status = status_ff;
      if (rd_status) nxt_status = 1'b0;
      if (in_conv && sar_done && !start_rise) nxt_status = 1'b1;
   end

   // interrupt level needs both enables, the mask and room on the stack
   always_comb begin
      nxt_irq = status_ff && mask_ff && global_en && conv_en && !stack_full;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_ff <= ST_IDLE;
         busy_ff <= 1'b0;
         status_ff <= 1'b0;
         irq_ff <= 1'b0;
         sample_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         busy_ff <= nxt_busy;
         status_ff <= nxt_status;
         irq_ff <= nxt_irq;
         sample_ff <= (nxt_st == ST_ARMED);
      end
   end

   // control register A: start, power-off, channel low bits
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         start_ff <= CTRL_A_RST[CA_START_BIT];
         poff_ff <= CTRL_A_RST[CA_POFF_BIT];
         chan_ff[3:0] <= CHAN_RST[3:0];
      end else if (wr_ctrl_a) begin
         start_ff <= start_new;
         poff_ff <= reg_wdata[CA_POFF_BIT];
         chan_ff[3:0] <= reg_wdata[3:0];
      end
   end

   // control register B: channel top bit, clock select
   // changing the clock select mid-conversion is allowed but stretches or shortens it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         chan_ff[4] <= CHAN_RST[4];
         div_sel_ff <= DIV_SEL_RST;
      end else if (wr_ctrl_b) begin
         chan_ff[4] <= reg_wdata[CB_CH4_BIT];
         div_sel_ff <= reg_wdata[2:0];
      end
   end

   // pin enables, low eight and high four
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_en_ff <= PIN_EN_RST;
      end else begin
         if (wr_pin_lo) pin_en_ff[7:0] <= reg_wdata;
         if (wr_pin_hi) pin_en_ff[11:8] <= reg_wdata[3:0];
      end
   end

   // interrupt enables and mask
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_en_ff <= 2'h0;
         mask_ff <= 1'b0;
      end else begin
         if (wr_irq_en) irq_en_ff <= reg_wdata[1:0];
         if (wr_mask) mask_ff <= reg_wdata[ST_DONE_BIT];
      end
   end

   // read mux; unmapped offsets read zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         ADDR_CTRL_A: rd_mux = {start_ff, busy_ff, poff_ff, 1'b0, chan_ff[3:0]};
         ADDR_CTRL_B: rd_mux = {chan_ff[4], 4'h0, div_sel_ff};
         ADDR_PIN_LO: rd_mux = pin_en_ff[7:0];
         ADDR_PIN_HI: rd_mux = {4'h0, pin_en_ff[11:8]};
         ADDR_RES_LO: rd_mux = sar_result[7:0];
         ADDR_RES_HI: rd_mux = {4'h0, sar_result[11:8]};
         ADDR_IRQ_EN: rd_mux = {6'h00, irq_en_ff};
         ADDR_IRQ_STAT: rd_mux = {7'h00, status_ff};
         ADDR_IRQ_MASK: rd_mux = {7'h00, mask_ff};
         default: rd_mux = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= reg_rd ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n || sar_clear) begin
         run_ticks_ff <= 5'h00;
      end else if (conv_tick && run_ticks_ff != 5'h1f) begin
         run_ticks_ff <= 5'(run_ticks_ff + 5'h01);
      end
   end

   // the divider restarts on the falling start edge so every conversion has full periods
   adcs_clkdiv u_clkdiv (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .sel(div_sel_ff),
      .restart(start_fall),
      .tick(conv_tick)
   );

   adcs_sar u_sar (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clear(sar_clear),
      .run(in_conv),
      .tick(conv_tick),
      .cmp_above(cmp_above),
      .dac_threshold(sar_dac),
      .result(sar_result),
      .done(sar_done)
   );

   assign reg_rdata = rdata_ff;
   assign dac_threshold = sar_dac;
   assign sample_hold = sample_ff;
   assign converter_power_off = poff_ff;
   assign input_channel_sel = chan_ff;
   assign analog_pin_enables = pin_en_ff;
   assign conv_busy_flag = busy_ff;
   assign irq = irq_ff;

   busy_on_rise_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (start_rise && !poff_next) |=> (busy_ff && st_ff == ST_ARMED && sample_hold))
   else $error("start rising edge did not arm converter");

   busy_drop_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (in_conv && sar_done && !start_rise) |=> (!busy_ff && st_ff == ST_IDLE))
   else $error("busy flag not cleared at completion");

   conv_length_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (in_conv && sar_done) |-> (run_ticks_ff == CONV_TICKS))
   else $error("conversion did not last sixteen conversion clocks");

   done_flag_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (in_conv && sar_done && !start_rise) |=> (status_ff ##1 $past(sar_result) == sar_result))
   else $error("completion did not set request flag");

   irq_gate_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq |-> ($past(global_en) && $past(conv_en) && $past(status_ff) && $past(mask_ff)))
   else $error("interrupt raised without both enables");

   irq_stack_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq |-> !$past(stack_full))
   else $error("interrupt raised while stack full");

   power_off_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      converter_power_off |-> (!busy_ff && st_ff == ST_IDLE && !sar_done))
   else $error("converter active while powered off");

   abort_restart_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (in_conv && start_rise && !poff_next) |=> (st_ff == ST_ARMED && busy_ff) ##1 !sar_done)
   else $error("restart during conversion not honoured");

   chan_low_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_ctrl_a |=> (input_channel_sel[3:0] == $past(reg_wdata[3:0])))
   else $error("channel low bits not taken from write");

   chan_top_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_ctrl_b |=> (input_channel_sel[4] == $past(reg_wdata[CB_CH4_BIT])))
   else $error("channel top bit not taken from write");

   pin_low_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_pin_lo |=> (analog_pin_enables[7:0] == $past(reg_wdata)))
   else $error("low pin enables not taken from write");

   pin_high_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_pin_hi |=> (analog_pin_enables[11:8] == $past(reg_wdata[3:0])))
   else $error("high pin enables not taken from write");

   div_select_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_ctrl_b |=> (div_sel_ff == $past(reg_wdata[2:0])))
   else $error("clock select not taken from write");

   undef_still_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (div_sel_ff == DIV_UNDEF && $past(div_sel_ff) == DIV_UNDEF) |-> !conv_tick)
   else $error("conversion clock runs on undefined select");

   power_bit_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_ctrl_a |=> (converter_power_off == $past(reg_wdata[CA_POFF_BIT])))
   else $error("power-off output not taken from write");

   busy_hold_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (in_conv && !sar_done) |-> conv_busy_flag)
   else $error("busy flag low while converting");

   sample_drop_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_ff == ST_ARMED && start_fall && !poff_next) |=> (in_conv && !sample_hold))
   else $error("falling start edge did not begin conversion");

   result_hold_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(sar_result) |-> sar_done)
   else $error("result changed outside completion");

   status_clear_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rd_status && !(in_conv && sar_done && !start_rise)) |=> !status_ff)
   else $error("status flag not cleared by read");

   rdata_idle_a:
   assert property (@(posedge ref_clk) disable iff (!rst_n)
      !$past(reg_rd) |-> (reg_rdata == 8'h00))
   else $error("read data not zero outside read cycle");
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import adcs_pkg::*;
   logic ref_clk, rst_n, reg_wr, reg_rd, stack_full, cmp_above;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [12:0] dac_threshold, vin;
   logic sample_hold, converter_power_off, conv_busy_flag, irq;
   logic [4:0] input_channel_sel, ch;
   logic [11:0] analog_pin_enables, pins, lastc;
   logic [31:0] r;
   int fails, n_tests, cyc, t0;

   // ideal comparator: input held in half-step units against the trial threshold
   assign cmp_above = vin >= dac_threshold;

   adcs_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_above(cmp_above),
      .stack_full(stack_full), .dac_threshold(dac_threshold), .sample_hold(sample_hold),
      .converter_power_off(converter_power_off), .input_channel_sel(input_channel_sel),
      .analog_pin_enables(analog_pin_enables), .conv_busy_flag(conv_busy_flag), .irq(irq));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) cyc <= cyc + 1;

   task automatic stop_test;
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("Error t=%0t register read %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_port(input logic [19:0] g, input logic [19:0] e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("Error t=%0t port value %h expected %h", $time, g, e);
      end
   endtask

   // strobes start with a fresh edge, so back-to-back calls never drive one signal twice per step
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic conv(input logic [2:0] sel, input logic [12:0] h, input logic [1:0] ien,
                       input logic msk, input logic sf, input logic ab);
      logic [11:0] c;
      int t;
      c = (h == 13'h1fff) ? 12'hfff : 12'((h + 13'd1) >> 1);
      @(posedge ref_clk);
      vin <= h;
      stack_full <= sf;
      wr(ADDR_CTRL_B, {ch[4], 4'h0, sel});
      wr(ADDR_CTRL_A, {4'h8, ch[3:0]});
      chk_port(20'(sample_hold & conv_busy_flag), 20'h1);
      wr(ADDR_CTRL_A, {4'h0, ch[3:0]});
      t0 = cyc;
      if (ab) begin
         wait_cyc(8 << sel);
         wr(ADDR_CTRL_A, {4'h8, ch[3:0]});
         chk_port(20'(conv_busy_flag), 20'h1);
         wr(ADDR_CTRL_A, {4'h0, ch[3:0]});
         t0 = cyc;
      end
      rd(ADDR_IRQ_STAT);
      wr(ADDR_IRQ_EN, {6'h0, ien});
      wr(ADDR_IRQ_MASK, {7'h0, msk});
      chk_port(20'(conv_busy_flag), 20'h1);
      t = 0;
      while (conv_busy_flag === 1'b1 && t < 9000) begin
         @(posedge ref_clk);
         #1;
         t++;
      end
      chk_port(20'((cyc - t0 >= (16 << sel)) && (cyc - t0 <= (16 << sel) + 3)), 20'h1);
      wait_cyc(1);
      chk_port(20'(irq), 20'(ien == 2'd3 && msk && !sf));
      rd(ADDR_RES_LO);
      chk_reg(d, c[7:0]);
      rd(ADDR_RES_HI);
      chk_reg(d & 8'h0f, {4'h0, c[11:8]});
      rd(ADDR_IRQ_STAT);
      chk_reg(d, 8'h01);
      rd(ADDR_IRQ_STAT);
      chk_reg(d, 8'h00);
      chk_port(20'(irq), 20'h0);
      lastc = c;
   endtask

   // watchdog sized well above the longest expected run
   initial begin
      repeat (90000) @(posedge ref_clk);
      fails++;
      stop_test;
   end

   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      vin = 13'h0000;
      stack_full = 1'b0;
      fails = 0;
      n_tests = 0;
      void'($urandom(32'h964eab6b));
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk_port(20'(converter_power_off), 20'h1);
      chk_port({irq, conv_busy_flag, input_channel_sel, analog_pin_enables}, 20'h0);
      rd(ADDR_CTRL_A);
      chk_reg(d, CTRL_A_RST);
      rd(4'hf);
      chk_reg(d, 8'h00);
      r = $urandom;
      pins = r[11:0];
      ch = r[16:12];
      wr(ADDR_PIN_LO, pins[7:0]);
      wr(ADDR_PIN_HI, {4'h0, pins[11:8]});
      chk_port(20'(analog_pin_enables), 20'(pins));
      rd(ADDR_PIN_LO);
      chk_reg(d, pins[7:0]);
      wr(ADDR_CTRL_B, {ch[4], 7'h0});
      wr(ADDR_CTRL_A, {4'h0, ch[3:0]});
      chk_port(20'(input_channel_sel), 20'(ch));
      chk_port(20'(converter_power_off), 20'h0);
      // corners of the transfer function, then random traffic over divider codes 000 to 110
      conv(3'd0, 13'h0000, 2'd3, 1'b1, 1'b0, 1'b0);
      conv(3'd0, 13'h0001, 2'd3, 1'b1, 1'b0, 1'b0);
      conv(3'd1, 13'h0002, 2'd1, 1'b1, 1'b0, 1'b0);
      conv(3'd0, 13'h1ffe, 2'd3, 1'b1, 1'b1, 1'b0);
      conv(3'd2, 13'h1fff, 2'd3, 1'b0, 1'b0, 1'b1);
      for (int s = 0; s < 7; s++) begin
         r = $urandom;
         conv(3'(s), r[12:0], r[14:13], r[15], r[16], r[17]);
      end
      repeat (8) begin
         r = $urandom;
         conv(3'(r[20:18] % 3'd5), r[12:0], r[14:13], r[15], r[16], r[17]);
      end
      wr(ADDR_RES_HI, 8'hff);
      rd(ADDR_RES_HI);
      chk_reg(d & 8'h0f, {4'h0, lastc[11:8]});
      // power-off during a conversion drops it with no completion
      wr(ADDR_CTRL_B, {ch[4], 4'h0, 3'd3});
      wr(ADDR_CTRL_A, {4'h8, ch[3:0]});
      wr(ADDR_CTRL_A, {4'h0, ch[3:0]});
      wait_cyc(20);
      wr(ADDR_CTRL_A, 8'h20);
      chk_port({converter_power_off, conv_busy_flag}, 20'h2);
      wait_cyc(200);
      rd(ADDR_IRQ_STAT);
      chk_reg(d, 8'h00);
      wr(ADDR_CTRL_A, 8'ha0);
      chk_port({sample_hold, conv_busy_flag}, 20'h0);
      wr(ADDR_CTRL_A, 8'h20);
      // undefined divider code gives no conversion clock
      wr(ADDR_CTRL_A, {4'h0, ch[3:0]});
      wr(ADDR_CTRL_B, {ch[4], 4'h0, DIV_UNDEF});
      wr(ADDR_CTRL_A, {4'h8, ch[3:0]});
      wr(ADDR_CTRL_A, {4'h0, ch[3:0]});
      wait_cyc(300);
      chk_port(20'(conv_busy_flag), 20'h1);
      wr(ADDR_CTRL_A, 8'h20);
      chk_port(20'(conv_busy_flag), 20'h0);
      stop_test;
   end
endmodule
